/* logic/fhs_fault_hiccup_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Before both biases pass reset level, keep low gate pulled to switch node.
// - Losing either bias returns to pre-reset protection, abandoning active drive.
// - Open-sense comparator trip shuts the controller down.
// - When open-sense trip clears, restart from the very start of soft-start.
// - Overcurrent comparator trip declares an overcurrent event.
// - Entering overcurrent shutdown turns off upper and lower drive at once.
// - Hold overcurrent all-off state exactly 4096 switching cycles.
// - At end of wait, begin new soft-start if still enabled.
// - Repeat trip, wait, retry without limit while fault persists.
// - Pull power-good low on undervoltage, overvoltage or overcurrent.
// - Soft-start waits 16 cycles, then one 12.5mV step every 16 cycles.
// - In shutdown the pulse-width outputs are high impedance.
module fhs_fault_hiccup_sequencer (
	input wire logic mclk,
	input wire logic reset,
	input wire logic driverBiasOk,
	input wire logic ctrlBiasOk,
	input wire logic enable,
	input wire logic openSenseTrip,
	input wire logic overcurrentTrip,
	input wire logic underVoltTrip,
	input wire logic overVoltTrip,
	input wire logic phaseClk,
	input wire logic [7:0] refTarget,
	output logic lowGatePullEn,
	output logic pwmDriveEn,
	output logic powerGoodOutOe,
	output logic powerGoodOutO,
	output logic overcurrentEvent,
	output logic [7:0] refCode
);
	logic [fhs_pkg::IN_W-1:0] meta1_r, meta2_r, meta3_r, filt_r, filtNxt;
	logic [7:0] tgt1_r, tgt2_r, tgt3_r, tgt_r, tgtNxt;
	logic phaseD_r;
	logic tick, biasOk, fOpen, fOc, fEn;
	fhs_pkg::fhs_state_t state_r, stateNxt;
	logic [11:0] cnt_r, cntNxt;
	logic [7:0] ref_r, refNxt;
	logic pull_r, pullNxt, pwm_r, pwmNxt, pgOe_r, pgOeNxt, ocEv_r, ocEvNxt;

	// A change is accepted only once the last two stages agree
	always_comb begin
		filtNxt = filt_r;
		tgtNxt = tgt_r;
		for (int i = 0; i < fhs_pkg::IN_W; i++) begin
			if (meta2_r[i] == meta3_r[i]) begin
				filtNxt[i] = meta3_r[i];
			end
		end
		if (tgt2_r == tgt3_r) begin
			tgtNxt = tgt3_r;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			meta1_r <= fhs_pkg::IN_RESET;
			meta2_r <= fhs_pkg::IN_RESET;
			meta3_r <= fhs_pkg::IN_RESET;
			filt_r <= fhs_pkg::IN_RESET;
			tgt1_r <= fhs_pkg::REF_RESET;
			tgt2_r <= fhs_pkg::REF_RESET;
			tgt3_r <= fhs_pkg::REF_RESET;
			tgt_r <= fhs_pkg::REF_RESET;
			phaseD_r <= 1'b0;
		end else begin
			meta1_r <= {1'b0, phaseClk, overVoltTrip, underVoltTrip, overcurrentTrip,
				openSenseTrip, enable, ctrlBiasOk, driverBiasOk};
			meta2_r <= meta1_r;
			meta3_r <= meta2_r;
			filt_r <= filtNxt;
			tgt1_r <= refTarget;
			tgt2_r <= tgt1_r;
			tgt3_r <= tgt2_r;
			tgt_r <= tgtNxt;
			phaseD_r <= filt_r[fhs_pkg::IN_PH];
		end
	end

	assign tick = filt_r[fhs_pkg::IN_PH] & ~phaseD_r;
	assign biasOk = filt_r[fhs_pkg::IN_DRV] & filt_r[fhs_pkg::IN_CTL];
	assign fOpen = filt_r[fhs_pkg::IN_OPEN];
	assign fOc = filt_r[fhs_pkg::IN_OC];
	assign fEn = filt_r[fhs_pkg::IN_EN];

	always_comb begin
		stateNxt = state_r;
		cntNxt = cnt_r;
		refNxt = ref_r;
		if (!biasOk) begin
			stateNxt = fhs_pkg::ST_PREPOR;
			cntNxt = fhs_pkg::CNT_RESET;
			refNxt = fhs_pkg::REF_RESET;
		end else begin
			case (state_r)
				fhs_pkg::ST_PREPOR: begin
					stateNxt = fhs_pkg::ST_SHUTDOWN;
				end
				fhs_pkg::ST_OPENSENSE: begin
					if (!fOpen) begin
						stateNxt = fhs_pkg::ST_SSDELAY;
						cntNxt = fhs_pkg::CNT_RESET;
						refNxt = fhs_pkg::REF_RESET;
					end
				end
				fhs_pkg::ST_SHUTDOWN: begin
					if (fOpen) begin
						stateNxt = fhs_pkg::ST_OPENSENSE;
					end else if (fEn) begin
						stateNxt = fhs_pkg::ST_SSDELAY;
						cntNxt = fhs_pkg::CNT_RESET;
						refNxt = fhs_pkg::REF_RESET;
					end
				end
				fhs_pkg::ST_OCWAIT: begin
					if (fOpen) begin
						stateNxt = fhs_pkg::ST_OPENSENSE;
						cntNxt = fhs_pkg::CNT_RESET;
					end else if (!fEn) begin
						stateNxt = fhs_pkg::ST_SHUTDOWN;
						cntNxt = fhs_pkg::CNT_RESET;
					end else if (tick) begin
						if (cnt_r == fhs_pkg::OC_WAIT_LAST) begin
							// Retry regardless of fault; a lasting fault trips again
							stateNxt = fhs_pkg::ST_SSDELAY;
							cntNxt = fhs_pkg::CNT_RESET;
							refNxt = fhs_pkg::REF_RESET;
						end else begin
							cntNxt = cnt_r + 12'h001;
						end
					end
				end
				default: begin
					if (fOpen) begin
						stateNxt = fhs_pkg::ST_OPENSENSE;
						cntNxt = fhs_pkg::CNT_RESET;
					end else if (!fEn) begin
						stateNxt = fhs_pkg::ST_SHUTDOWN;
						cntNxt = fhs_pkg::CNT_RESET;
					end else if (fOc) begin
						stateNxt = fhs_pkg::ST_OCWAIT;
						cntNxt = fhs_pkg::CNT_RESET;
					end else if (state_r != fhs_pkg::ST_RUN && tick) begin
						if (cnt_r != fhs_pkg::SS_STEP_LAST) begin
							cntNxt = cnt_r + 12'h001;
						end else begin
							cntNxt = fhs_pkg::CNT_RESET;
							if (state_r == fhs_pkg::ST_SSDELAY) begin
								stateNxt = (tgt_r == ref_r) ? fhs_pkg::ST_RUN : fhs_pkg::ST_RAMP;
							end else if (ref_r < tgt_r) begin
								refNxt = ref_r + fhs_pkg::REF_STEP;
								if (refNxt == tgt_r) begin
									stateNxt = fhs_pkg::ST_RUN;
								end
							end else begin
								stateNxt = fhs_pkg::ST_RUN;
							end
						end
					end
				end
			endcase
		end
		pullNxt = (stateNxt == fhs_pkg::ST_PREPOR);
		// PWM drive only while ramping or running; otherwise high impedance
		pwmNxt = (stateNxt == fhs_pkg::ST_RAMP) || (stateNxt == fhs_pkg::ST_RUN);
		pgOeNxt = !(stateNxt == fhs_pkg::ST_RUN) || filt_r[fhs_pkg::IN_UV] ||
			filt_r[fhs_pkg::IN_OV] || fOc;
		ocEvNxt = (stateNxt == fhs_pkg::ST_OCWAIT) && (state_r != fhs_pkg::ST_OCWAIT);
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_r <= fhs_pkg::ST_PREPOR;
			cnt_r <= fhs_pkg::CNT_RESET;
			ref_r <= fhs_pkg::REF_RESET;
			pull_r <= 1'b1;
			pwm_r <= 1'b0;
			pgOe_r <= 1'b1;
			ocEv_r <= 1'b0;
		end else begin
			state_r <= stateNxt;
			cnt_r <= cntNxt;
			ref_r <= refNxt;
			pull_r <= pullNxt;
			pwm_r <= pwmNxt;
			pgOe_r <= pgOeNxt;
			ocEv_r <= ocEvNxt;
		end
	end

	assign lowGatePullEn = pull_r;
	assign pwmDriveEn = pwm_r;
	assign powerGoodOutOe = pgOe_r;
	assign powerGoodOutO = 1'b0;
	assign overcurrentEvent = ocEv_r;
	assign refCode = ref_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_prepor_pull: assert property (!biasOk |=> lowGatePullEn && !pwmDriveEn)
		else $error("pull path not active without bias");
	a_bias_loss: assert property ($fell(biasOk) |=> state_r == fhs_pkg::ST_PREPOR)
		else $error("bias loss did not return to pre-reset state");
	a_open_shut: assert property (biasOk && fOpen && state_r != fhs_pkg::ST_PREPOR
		|=> state_r == fhs_pkg::ST_OPENSENSE && !pwmDriveEn)
		else $error("open sense did not shut down");
	a_open_restart: assert property (biasOk && !fOpen && state_r == fhs_pkg::ST_OPENSENSE
		|=> state_r == fhs_pkg::ST_SSDELAY && refCode == 8'h00 && cnt_r == 12'h000)
		else $error("open sense clear did not restart soft-start");
	a_oc_enter: assert property (biasOk && !fOpen && fEn && fOc &&
		(state_r == fhs_pkg::ST_RAMP || state_r == fhs_pkg::ST_RUN)
		|=> state_r == fhs_pkg::ST_OCWAIT && !pwmDriveEn && overcurrentEvent &&
		cnt_r == 12'h000)
		else $error("overcurrent did not shut drives");
	// No way out of the wait before the last tick while still enabled, both biases good and open sense clear
	a_oc_hold: assert property (state_r == fhs_pkg::ST_OCWAIT && biasOk && !fOpen && fEn &&
		!(tick && cnt_r == fhs_pkg::OC_WAIT_LAST)
		|=> state_r == fhs_pkg::ST_OCWAIT && !pwmDriveEn)
		else $error("overcurrent wait ended early");
	a_oc_count: assert property (state_r == fhs_pkg::ST_OCWAIT && biasOk && !fOpen && fEn &&
		tick && cnt_r != fhs_pkg::OC_WAIT_LAST |=> cnt_r == $past(cnt_r) + 12'h001)
		else $error("overcurrent wait count skipped");
	a_oc_retry: assert property (state_r == fhs_pkg::ST_OCWAIT && biasOk && !fOpen && fEn &&
		tick && cnt_r == fhs_pkg::OC_WAIT_LAST |=> state_r == fhs_pkg::ST_SSDELAY)
		else $error("no retry after overcurrent wait");
	a_pg_low: assert property (filt_r[fhs_pkg::IN_UV] || filt_r[fhs_pkg::IN_OV] || fOc
		|=> powerGoodOutOe)
		else $error("power good not pulled low on fault");
	a_ramp_step: assert property (state_r == fhs_pkg::ST_RAMP && biasOk && !fOpen && fEn &&
		!fOc && tick && cnt_r == fhs_pkg::SS_STEP_LAST && ref_r < tgt_r
		|=> refCode == $past(ref_r) + 8'h01)
		else $error("reference step missing");
	a_shut_hiz: assert property (state_r == fhs_pkg::ST_SHUTDOWN ||
		state_r == fhs_pkg::ST_SSDELAY |-> !pwmDriveEn)
		else $error("pwm driven in shutdown");
	a_oc_disable: assert property (state_r == fhs_pkg::ST_OCWAIT && biasOk && !fOpen && !fEn
		|=> state_r == fhs_pkg::ST_SHUTDOWN && cnt_r == 12'h000)
		else $error("disable during wait not honoured");

	c_reach_run: cover property (state_r == fhs_pkg::ST_RAMP ##1 state_r == fhs_pkg::ST_RUN);
	c_hiccup: cover property (state_r == fhs_pkg::ST_OCWAIT ##1 state_r == fhs_pkg::ST_SSDELAY);
	c_open: cover property (state_r == fhs_pkg::ST_OPENSENSE ##1 state_r == fhs_pkg::ST_SSDELAY);
	c_bias_drop: cover property (state_r == fhs_pkg::ST_RUN ##1 state_r == fhs_pkg::ST_PREPOR);
endmodule
`default_nettype wire

/* logic/fhs_pkg.sv */
package fhs_pkg;
	// Switching cycles held off after an overcurrent trip
	localparam int OC_WAIT_CYCLES = 4096;
	localparam logic [11:0] OC_WAIT_LAST = 12'hfff;
	// Soft-start delay and per-step spacing, in switching cycles
	localparam int SS_STEP_CYCLES = 16;
	localparam logic [11:0] SS_STEP_LAST = 12'h00f;
	localparam logic [11:0] CNT_RESET = 12'h000;
	localparam logic [7:0] REF_RESET = 8'h00;
	localparam logic [7:0] REF_STEP = 8'h01;
	// Filtered input vector layout
	localparam int IN_W = 9;
	localparam int IN_DRV = 0;
	localparam int IN_CTL = 1;
	localparam int IN_EN = 2;
	localparam int IN_OPEN = 3;
	localparam int IN_OC = 4;
	localparam int IN_UV = 5;
	localparam int IN_OV = 6;
	localparam int IN_PH = 7;
	localparam int IN_SPARE = 8;
	localparam logic [IN_W-1:0] IN_RESET = 9'h000;
	typedef enum logic [6:0] {
		ST_PREPOR = 7'h01,
		ST_SHUTDOWN = 7'h02,
		ST_SSDELAY = 7'h04,
		ST_RAMP = 7'h08,
		ST_RUN = 7'h10,
		ST_OCWAIT = 7'h20,
		ST_OPENSENSE = 7'h40
	} fhs_state_t;
endpackage

/* verif/fhs_power_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fhs_power_stage_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic pwmDriveEn,
	input wire logic overload,
	input wire logic senseOpen,
	output logic phaseClk,
	output logic overcurrentTrip,
	output logic openSenseTrip
);
	logic [2:0] phaseCnt_r;
	// Eight mclk per switching cycle keeps every level at least 3 mclk wide
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			phaseCnt_r <= 3'h0;
		end else begin
			phaseCnt_r <= phaseCnt_r + 3'h1;
		end
	end
	assign phaseClk = phaseCnt_r[2];
	// No load current and no sense rise while the stage is not switching
	assign overcurrentTrip = pwmDriveEn & overload;
	assign openSenseTrip = pwmDriveEn & senseOpen;
endmodule
`default_nettype wire

/* verif/fhs_fault_hiccup_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
	$display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module fhs_fault_hiccup_sequencer_tb_top;
	logic mclk = 1'b0, reset = 1'b1, drvOk = 1'b0, ctlOk = 1'b0, enable = 1'b0;
	logic overload = 1'b0, senseOpen = 1'b0, uvTrip = 1'b0, ovTrip = 1'b0;
	logic phaseClk, ocTrip, openTrip, lowPull, pwmEn, pgOe, pgO, ocEvent;
	logic [7:0] refTarget = 8'h00, refCode;
	logic [15:0] seed = 16'h6d17;
	int error_cnt = 0, num_checks = 0, n;
	always #10 mclk = ~mclk;
	fhs_power_stage_model fhs_power_stage_model_i (.mclk(mclk), .reset(reset),
		.pwmDriveEn(pwmEn), .overload(overload), .senseOpen(senseOpen),
		.phaseClk(phaseClk), .overcurrentTrip(ocTrip), .openSenseTrip(openTrip));
	fhs_fault_hiccup_sequencer fhs_fault_hiccup_sequencer_i (.mclk(mclk), .reset(reset),
		.driverBiasOk(drvOk), .ctrlBiasOk(ctlOk), .enable(enable),
		.openSenseTrip(openTrip), .overcurrentTrip(ocTrip), .underVoltTrip(uvTrip),
		.overVoltTrip(ovTrip), .phaseClk(phaseClk), .refTarget(refTarget),
		.lowGatePullEn(lowPull), .pwmDriveEn(pwmEn), .powerGoodOutOe(pgOe),
		.powerGoodOutO(pgO), .overcurrentEvent(ocEvent), .refCode(refCode));
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic wait_code(input logic [7:0] v, input int lim);
		n = 0;
		while (refCode !== v && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic wait_oc();
		n = 0;
		while (ocEvent !== 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
	endtask
	// Full soft-start from enable to regulation, step spacing measured in mclk
	task automatic ramp_up();
		wait_code(8'h01, 400);
		`CHK("firstStep", 8'h01, refCode)
		for (int k = 2; k <= refTarget; k++) begin
			wait_code(k[7:0], 300);
			`CHK("stepGap", 128, n)
		end
		cyc(4);
		`CHK("runPwm", 1'b1, pwmEn)
		`CHK("runPg", 1'b0, pgOe)
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge mclk);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		cyc(7);
		`CHK("rstPull", 1'b1, lowPull)
		`CHK("rstPwm", 1'b0, pwmEn)
		@(posedge mclk) reset <= 1'b0;
		cyc(20);
		`CHK("prePull", 1'b1, lowPull)
		seed = lfsr_next(seed);
		@(posedge mclk) begin
			drvOk <= 1'b1;
			ctlOk <= 1'b1;
			enable <= 1'b1;
			refTarget <= 8'h03 + {6'h00, seed[1:0]};
		end
		cyc(20);
		`CHK("postPull", 1'b0, lowPull)
		ramp_up();
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk) {uvTrip, ovTrip} <= i ? 2'b01 : 2'b10;
			cyc(10);
			`CHK("pgTrip", 1'b1, pgOe)
			`CHK("pgLevel", 1'b0, pgO)
			`CHK("pgPwm", 1'b1, pwmEn)
			@(posedge mclk) {uvTrip, ovTrip} <= 2'b00;
			cyc(10);
			`CHK("pgBack", 1'b0, pgOe)
		end
		@(posedge mclk) overload <= 1'b1;
		wait_oc();
		`CHK("ocEvent", 1'b1, ocEvent)
		cyc(1);
		`CHK("ocPulse", 1'b0, ocEvent)
		`CHK("ocOff", 1'b0, pwmEn)
		`CHK("ocPg", 1'b1, pgOe)
		n = 0;
		while (pwmEn !== 1'b1 && n < 34000) begin
			cyc(1);
			n++;
		end
		// 4096 + 16 ticks of 8 mclk; entry phase spreads the first tick over 8 mclk
		`CHK("ocWait", 1'b1, n >= 32888 && n <= 32895)
		wait_oc();
		`CHK("retrip", 1'b1, ocEvent)
		cyc(100);
		@(posedge mclk) begin
			enable <= 1'b0;
			overload <= 1'b0;
		end
		n = 0;
		repeat (34000) begin
			cyc(1);
			n += (pwmEn !== 1'b0) ? 1 : 0;
		end
		`CHK("noRetry", 0, n)
		@(posedge mclk) enable <= 1'b1;
		ramp_up();
		@(posedge mclk) senseOpen <= 1'b1;
		cyc(12);
		`CHK("openOff", 1'b0, pwmEn)
		`CHK("openPg", 1'b1, pgOe)
		@(posedge mclk) senseOpen <= 1'b0;
		cyc(12);
		`CHK("openCode", 8'h00, refCode)
		ramp_up();
		@(posedge mclk) drvOk <= 1'b0;
		cyc(12);
		`CHK("drvLossPull", 1'b1, lowPull)
		`CHK("drvLossPwm", 1'b0, pwmEn)
		@(posedge mclk) drvOk <= 1'b1;
		ramp_up();
		@(posedge mclk) ctlOk <= 1'b0;
		cyc(12);
		`CHK("ctlLossPull", 1'b1, lowPull)
		`CHK("ctlLossPwm", 1'b0, pwmEn)
		tally_and_finish();
	end
endmodule
`default_nettype wire
